// file: core/dictl_cfg.svh
/*
 * Register map, field positions, reset values and soft reset timing of the
 * deinterlacer control register bank.
 * Assumes inclusion by the register bank only.
 */
`ifndef DICTL_CFG_SVH
`define DICTL_CFG_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define DICTL_OFS_CORE_CONTROL   12'h000
`define DICTL_OFS_OPERATING_MODE 12'h004
`define DICTL_OFS_IRQ_ENABLE     12'h008
`define DICTL_OFS_IRQ_FLAGS      12'h00C
`define DICTL_OFS_FRAME_HEIGHT   12'h010
`define DICTL_OFS_FRAME_WIDTH    12'h014
`define DICTL_OFS_LOW_LIMIT      12'h018
`define DICTL_OFS_HIGH_LIMIT     12'h01C
`define DICTL_OFS_CROSSFADE      12'h020
`define DICTL_OFS_STORE_A_BASE   12'h024
`define DICTL_OFS_STORE_B_BASE   12'h028
`define DICTL_OFS_STORE_C_BASE   12'h02C
`define DICTL_OFS_SEGMENT_SIZE   12'h030
`define DICTL_OFS_HW_VERSION     12'h0F0
`define DICTL_OFS_SOFT_RESET     12'h100

// ************************************************************
// field widths and masks
// ************************************************************
`define DICTL_CTRL_MASK     32'h0000_0007
`define DICTL_MODE_MASK     32'h0003_03FF
`define DICTL_IRQ_MASK      32'h0000_0F7F
`define DICTL_SIZE_MASK     32'h0000_07FF
`define DICTL_LIMIT_MASK    32'h0000_03FF
`define DICTL_XFADE_MASK    32'h0000_FFFF
`define DICTL_SEGMENT_MASK  32'h00FF_FFFF
`define DICTL_RESET_VALUE   32'h0000_0000

// ************************************************************
// bit positions
// ************************************************************
`define DICTL_CTRL_UPDATE   0
`define DICTL_CTRL_ENABLE   1
`define DICTL_CTRL_ACCEPT   2
`define DICTL_SRST_BIT      0

// soft reset length in ns and cycles at 200 MHz (5 ns period)
`define DICTL_SRST_TIME_NS  80
`define DICTL_CLK_PERIOD_NS 5
`define DICTL_SRST_CYCLES   ((`DICTL_SRST_TIME_NS + `DICTL_CLK_PERIOD_NS - 1) / `DICTL_CLK_PERIOD_NS)

`endif

// file: core/dictl_pkg.sv
/*
 * Types shared by the deinterlacer control register bank and its users.
 * Assumes dictl_cfg.svh for the numeric layout.
 */
`default_nettype none

package dictl_pkg;

  // deinterlacing method
  typedef enum logic [1:0] {
    DICTL_ALG_FIELD_INTERP = 2'h0,
    DICTL_ALG_DIAGONAL     = 2'h1,
    DICTL_ALG_MOTION       = 2'h2,
    DICTL_ALG_BOTH         = 2'h3
  } dictl_alg_e;

  // chroma packing on input and output
  typedef enum logic [1:0] {
    DICTL_PACK_420 = 2'h0,
    DICTL_PACK_422 = 2'h1,
    DICTL_PACK_444 = 2'h2,
    DICTL_PACK_RSV = 2'h3
  } dictl_pack_e;

  // soft reset sequencer, gray along idle -> busy -> done
  typedef enum logic [1:0] {
    DICTL_SR_IDLE = 2'h0,
    DICTL_SR_BUSY = 2'h1,
    DICTL_SR_DONE = 2'h3
  } dictl_sr_e;

  // operating mode register layout, msb first
  typedef struct packed {
    logic [13:0] rsv_hi;
    logic        colour_diag;
    logic        colour_motion;
    logic [5:0]  rsv_mid;
    logic        pd22_phase_swap;
    logic        pd22_enable;
    logic        pd32_enable;
    logic        segmented_frame_mode;
    logic        field_order_ntsc;
    dictl_pack_e packing;
    logic        colour_rgb;
    dictl_alg_e  algorithm;
  } dictl_mode_s;

  // event strobes from the video path, one per status position except bit 0
  typedef struct packed {
    logic rd1_underrun;
    logic rd0_underrun;
    logic wr_overrun;
    logic wr_marker;
    logic frame_passed;
    logic pulldown_off;
    logic pulldown_on;
    logic input_overrun;
    logic sync_lost;
    logic sync_locked;
  } dictl_events_s;

  // settings handed to the video path, accept at input frame start and the rest after shadow update
  typedef struct packed {
    logic        enable;
    logic        accept;
    dictl_mode_s mode;
    logic [10:0] height;
    logic [10:0] width;
    logic [9:0]  low_motion_limit;
    logic [9:0]  high_motion_limit;
    logic [15:0] crossfade;
    logic [31:0] store_a_base;
    logic [31:0] store_b_base;
    logic [31:0] store_c_base;
    logic [23:0] segment_size;
  } dictl_shadow_s;

endpackage : dictl_pkg

`default_nettype wire

// file: core/dictl_regs.sv
/*
 * Control and status register bank of the video deinterlacer.
 * Assumes a simple synchronous register port (select, write strobe, byte
 * address, data) on sys_clk, and frame boundary and event strobes from the
 * video path that are synchronous to the same clock.
 */
// Behaviour
// (R1) Writing update bit arms shadow update at next frame boundary; zero cancels it.
// (R2) Enable clear makes the video path pass active video unchanged.
// (R3) Blanking is always stripped, bypass included.
// (R4) Accept-video bit chooses take-in or ignore, applied at next input frame.
// (R5) Algorithm field: interp, diagonal, motion, or both engines.
// (R6) Colour-space bit: clear YUV, set RGB.
// (R7) Packing field: 0 is 4:2:0, 1 is 4:2:2, 2 is 4:4:4.
// (R8) Field-order bit set chooses NTSC ordering, clear PAL/HD/3G.
// (R9) Segmented-frame bit selects interlaced, segmented or progressive handling.
// (R10) Software enables motion engine whenever segmented-frame mode is set.
// (R11) Separate bits enable 3:2 and 2:2 cadence detector control.
// (R12) 2:2 precedence bit set swaps field phase internally.
// (R13) Two bits enable colourising with motion or diagonal result.
// (R14) Enable bits 0-6 and 8-11 gate the matching status bits.
// (R15) Status bit 0 sets when a shadow update takes place.
// (R16) Status bit 1 flags lock, bit 2 loss of lock.
// (R17) Status bit 3 flags input FIFO overrun.
// (R18) Status bit 4 cadence found, bit 5 cadence lost.
// (R19) Status bit 6 sets on every frame boundary passed.
// (R20) Status bit 8 flags framestore frames mismatching settings.
// (R21) Bit 9 write-port overrun, bits 10 and 11 read-port underruns.
// (R22) Software programs an even full frame height, counted from one.
// (R23) Software keeps width divisible by 4 or 2 with motion engine.
// (R24) Soft reset returns core to defaults, purges video, self-clears.
// (R25) Soft reset clears only control, mode and enable registers.
// (R26) Software reloads cross-fade scale whenever a threshold changes.
// (R27) Interrupt output is high while any enabled status bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "dictl_cfg.svh"

module dictl_regs
  import dictl_pkg::*;
#(
  parameter logic [31:0] HW_VERSION = 32'h0100_0000, // arbitrary value
  parameter int          SRST_LEN   = `DICTL_SRST_CYCLES
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // register port
  input  wire logic          reg_sel,
  input  wire logic          reg_wr,
  input  wire logic [11:0]   reg_addr,
  input  wire logic [31:0]   reg_wdata,
  output logic      [31:0]   reg_rdata,
  // video path timing and events
  input  wire logic          frame_boundary,
  input  wire logic          in_frame_start,
  input  wire dictl_events_s events,
  // settings and control to the video path
  output dictl_shadow_s      shadow,
  output logic               strip_blanking,
  output logic               core_purge,
  output logic               irq
);

  // ************************************************************
  // register storage
  // ************************************************************
  // software-visible registers, at field width except mode, enable and flags at 32 bits
  logic [2:0]  ctrl_q;
  logic [31:0] mode_q;
  logic [31:0] irq_en_q;
  logic [31:0] flags_q;
  logic [10:0] height_q;
  logic [10:0] width_q;
  logic [9:0]  low_q;
  logic [9:0]  high_q;
  logic [15:0] xfade_q;
  logic [31:0] base_a_q;
  logic [31:0] base_b_q;
  logic [31:0] base_c_q;
  logic [23:0] seg_q;

  // soft reset sequencer state
  logic        srst_q;
  dictl_sr_e   sr_state_q;
  logic [7:0]  sr_cnt_q;

  // shadow request, accept timing and internal strobes
  logic        pending_q;
  logic        accept_q;
  dictl_shadow_s shadow_q;
  logic        soft_clr;
  logic        update_now;
  logic [31:0] ev_vec;

  // write decode shared by every register
  function automatic logic hit(input logic [11:0] ofs);
    hit = reg_sel && reg_wr && (reg_addr == ofs);
  endfunction : hit

  // busy phase clears the control side and purges
  assign soft_clr   = (sr_state_q == DICTL_SR_BUSY);
  assign update_now = pending_q && frame_boundary;

  // ************************************************************
  // soft reset sequencer
  // ************************************************************
  // holds the purge for a fixed time so every pipeline stage drains
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sr_state_q <= DICTL_SR_IDLE;
      sr_cnt_q   <= 8'h00;
      srst_q     <= 1'b0;
    end else begin
      unique case (sr_state_q)
        DICTL_SR_IDLE: begin
          if (hit(`DICTL_OFS_SOFT_RESET) && reg_wdata[`DICTL_SRST_BIT]) begin
            sr_state_q <= DICTL_SR_BUSY; // R24
            srst_q     <= 1'b1;
            sr_cnt_q   <= 8'(SRST_LEN - 1);
          end
        end
        DICTL_SR_BUSY: begin
          // runs down from SRST_LEN-1, so SRST_LEN busy cycles
          if (sr_cnt_q == 8'h00) begin
            sr_state_q <= DICTL_SR_DONE;
          end else begin
            sr_cnt_q <= sr_cnt_q - 8'h01;
          end
        end
        DICTL_SR_DONE: begin
          // spare cycle: the bit still reads set, purge is over
          sr_state_q <= DICTL_SR_IDLE;
          srst_q     <= 1'b0; // R24
        end
        default: begin
          sr_state_q <= DICTL_SR_IDLE;
          srst_q     <= 1'b0;
        end
      endcase
    end
  end

  // purge is a state decode, so it never glitches
  assign core_purge = soft_clr; // R24

  // ************************************************************
  // control, mode and enable registers (cleared by soft reset)
  // ************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q   <= 3'h0;
      mode_q   <= `DICTL_RESET_VALUE;
      irq_en_q <= `DICTL_RESET_VALUE;
    end else if (soft_clr) begin
      ctrl_q   <= 3'h0; // R25
      mode_q   <= `DICTL_RESET_VALUE; // R25
      irq_en_q <= `DICTL_RESET_VALUE; // R25
    end else begin
      // update bit reads back as pending until a boundary takes it
      if (hit(`DICTL_OFS_CORE_CONTROL)) begin
        ctrl_q <= reg_wdata[2:0];
      end else if (update_now) begin
        ctrl_q[`DICTL_CTRL_UPDATE] <= 1'b0; // request consumed
      end
      if (hit(`DICTL_OFS_OPERATING_MODE)) begin
        mode_q <= reg_wdata & `DICTL_MODE_MASK; // R5 R6 R7 R8 R9 R11 R12 R13
      end
      if (hit(`DICTL_OFS_IRQ_ENABLE)) begin
        irq_en_q <= reg_wdata & `DICTL_IRQ_MASK; // R14
      end
    end
  end

  // shadow request: write 1 arms, write 0 cancels, boundary commits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (soft_clr) begin
      pending_q <= 1'b0;
    end else if (hit(`DICTL_OFS_CORE_CONTROL)) begin
      pending_q <= reg_wdata[`DICTL_CTRL_UPDATE]; // R1
    end else if (update_now) begin
      pending_q <= 1'b0; // R1
    end
  end

  // ************************************************************
  // settings registers (kept through soft reset)
  // ************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      height_q <= 11'h000;
      width_q  <= 11'h000;
      low_q    <= 10'h000;
      high_q   <= 10'h000;
      xfade_q  <= 16'h0000;
      base_a_q <= 32'h0000_0000;
      base_b_q <= 32'h0000_0000;
      base_c_q <= 32'h0000_0000;
      seg_q    <= 24'h00_0000;
    end else begin
      // no parity checks on height or width: software keeps them legal
      if (hit(`DICTL_OFS_FRAME_HEIGHT)) begin
        height_q <= reg_wdata[10:0]; // R22
      end
      if (hit(`DICTL_OFS_FRAME_WIDTH)) begin
        width_q <= reg_wdata[10:0]; // R23
      end
      if (hit(`DICTL_OFS_LOW_LIMIT)) begin
        low_q <= reg_wdata[9:0];
      end
      if (hit(`DICTL_OFS_HIGH_LIMIT)) begin
        high_q <= reg_wdata[9:0];
      end
      if (hit(`DICTL_OFS_CROSSFADE)) begin
        xfade_q <= reg_wdata[15:0]; // R26
      end
      if (hit(`DICTL_OFS_STORE_A_BASE)) begin
        base_a_q <= reg_wdata;
      end
      if (hit(`DICTL_OFS_STORE_B_BASE)) begin
        base_b_q <= reg_wdata;
      end
      if (hit(`DICTL_OFS_STORE_C_BASE)) begin
        base_c_q <= reg_wdata;
      end
      if (hit(`DICTL_OFS_SEGMENT_SIZE)) begin
        seg_q <= reg_wdata[23:0];
      end
    end
  end

  // ************************************************************
  // shadow copy seen by the video path
  // ************************************************************
  // settings move only at a frame boundary or in a soft reset purge, so a frame never mixes modes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shadow_q <= '0;
    end else if (soft_clr) begin
      // only the fields of cleared registers are dropped
      shadow_q.enable <= 1'b0;
      shadow_q.mode   <= '0;
    end else if (update_now) begin
      shadow_q.enable            <= ctrl_q[`DICTL_CTRL_ENABLE]; // R2
      shadow_q.mode              <= dictl_mode_s'(mode_q); // R5 R9 R10
      shadow_q.height            <= height_q;
      shadow_q.width             <= width_q;
      shadow_q.low_motion_limit  <= low_q;
      shadow_q.high_motion_limit <= high_q;
      shadow_q.crossfade         <= xfade_q;
      shadow_q.store_a_base      <= base_a_q;
      shadow_q.store_b_base      <= base_b_q;
      shadow_q.store_c_base      <= base_c_q;
      shadow_q.segment_size      <= seg_q;
    end
  end

  // accept-video follows its bit at an input frame start and clears in a soft reset purge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accept_q <= 1'b0;
    end else if (soft_clr) begin
      accept_q <= 1'b0;
    end else if (in_frame_start) begin
      accept_q <= ctrl_q[`DICTL_CTRL_ACCEPT]; // R4
    end
  end

  // accept keeps its own timing, the rest moves with the update
  always_comb begin
    shadow        = shadow_q;
    shadow.accept = accept_q; // R4
  end

  // no mode keeps blanking, so the level is fixed
  assign strip_blanking = 1'b1; // R3

  // ************************************************************
  // sticky status flags
  // ************************************************************
  always_comb begin
    ev_vec      = 32'h0000_0000;
    ev_vec[0]   = update_now; // R15
    ev_vec[1]   = events.sync_locked; // R16
    ev_vec[2]   = events.sync_lost; // R16
    ev_vec[3]   = events.input_overrun; // R17
    ev_vec[4]   = events.pulldown_on; // R18
    ev_vec[5]   = events.pulldown_off; // R18
    ev_vec[6]   = frame_boundary || events.frame_passed; // R19
    ev_vec[8]   = events.wr_marker; // R20
    ev_vec[9]   = events.wr_overrun; // R21
    ev_vec[10]  = events.rd0_underrun; // R21
    ev_vec[11]  = events.rd1_underrun; // R21
  end

  // writing one clears a flag; a new event in the same cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= `DICTL_RESET_VALUE;
    end else if (hit(`DICTL_OFS_IRQ_FLAGS)) begin
      flags_q <= (flags_q & ~reg_wdata) | ev_vec;
    end else begin
      flags_q <= flags_q | ev_vec;
    end
  end

  // level output; position 7 is masked and never raises it
  assign irq = |(flags_q & irq_en_q & `DICTL_IRQ_MASK); // R14 R27

  // ************************************************************
  // read mux
  // ************************************************************
  // read data is registered; unmapped offsets return zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_sel && !reg_wr) begin
      unique case (reg_addr)
        `DICTL_OFS_CORE_CONTROL:   reg_rdata <= {29'h0, ctrl_q};
        `DICTL_OFS_OPERATING_MODE: reg_rdata <= mode_q;
        `DICTL_OFS_IRQ_ENABLE:     reg_rdata <= irq_en_q;
        `DICTL_OFS_IRQ_FLAGS:      reg_rdata <= flags_q;
        `DICTL_OFS_FRAME_HEIGHT:   reg_rdata <= {21'h0, height_q};
        `DICTL_OFS_FRAME_WIDTH:    reg_rdata <= {21'h0, width_q};
        `DICTL_OFS_LOW_LIMIT:      reg_rdata <= {22'h0, low_q};
        `DICTL_OFS_HIGH_LIMIT:     reg_rdata <= {22'h0, high_q};
        `DICTL_OFS_CROSSFADE:      reg_rdata <= {16'h0, xfade_q};
        `DICTL_OFS_STORE_A_BASE:   reg_rdata <= base_a_q;
        `DICTL_OFS_STORE_B_BASE:   reg_rdata <= base_b_q;
        `DICTL_OFS_STORE_C_BASE:   reg_rdata <= base_c_q;
        `DICTL_OFS_SEGMENT_SIZE:   reg_rdata <= {8'h0, seg_q};
        `DICTL_OFS_HW_VERSION:     reg_rdata <= HW_VERSION;
        `DICTL_OFS_SOFT_RESET:     reg_rdata <= {31'h0, srst_q}; // R24
        default:                   reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : dictl_regs

`default_nettype wire

// file: verification/deinterlacer_control_registers_test.sv
/* Self-checking bench for the deinterlacer control register bank.
   Assumes dictl_host as processor and the bench as video path. */
`timescale 1ns/1ps
`default_nettype none
module deinterlacer_control_registers_test;
  import dictl_pkg::*;
  localparam logic [31:0] VER = 32'h0A5C_0003; // arbitrary value
  localparam logic [11:0] ADR [11] = '{12'h004, 12'h008, 12'h010, 12'h014, 12'h018, 12'h01C,
    12'h020, 12'h024, 12'h028, 12'h02C, 12'h030};
  localparam logic [31:0] MSK [11] = '{32'h0003_03FF, 32'h0000_0F7F, 32'h0000_07FF,
    32'h0000_07FF, 32'h0000_03FF, 32'h0000_03FF, 32'h0000_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_FFFF};
  logic          sys_clk = 1'b0;
  logic          resetn, frame_boundary, in_frame_start, reg_sel, reg_wr;
  logic          strip_blanking, core_purge, irq;
  logic [11:0]   reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, rd, v;
  dictl_events_s events;
  dictl_shadow_s shadow;
  dictl_mode_s   m, prev;
  int            fails = 0, samples_checked = 0, i, j;
  dictl_regs #(.HW_VERSION(VER), .SRST_LEN(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_boundary(frame_boundary), .in_frame_start(in_frame_start),
    .events(events), .shadow(shadow), .strip_blanking(strip_blanking),
    .core_purge(core_purge), .irq(irq));
  dictl_host i_host (.sys_clk(sys_clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ************************************************************
  // helpers
  // ************************************************************
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // status position of an event strobe, bit 7 is a hole in the map
  function automatic logic [31:0] exp_flag(input int idx);
    return 32'h1 << ((idx < 6) ? idx + 1 : idx + 2);
  endfunction : exp_flag
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.access(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    i_host.access(1'b0, a, 32'h0000_0000, rd);
    check(name, rd, exp);
  endtask : rdc
  task automatic fb_pulse;
    @(posedge sys_clk);
    #1 frame_boundary = 1'b1;
    @(posedge sys_clk);
    #1 frame_boundary = 1'b0;
  endtask : fb_pulse
  task automatic ev_pulse(input int idx);
    @(posedge sys_clk);
    #1 events = dictl_events_s'(10'h001 << idx);
    @(posedge sys_clk);
    #1 events = '0;
  endtask : ev_pulse
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // watchdog, the sequence needs a few hundred cycles
  initial begin
    #100000;
    fails++;
    close_out();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn = 1'b0;
    frame_boundary = 1'b0;
    in_frame_start = 1'b0;
    events = '0;
    prev = '0;
    void'($urandom(24));
    repeat (8) @(posedge sys_clk);
    #1 resetn = 1'b1;
    check("strip", strip_blanking, 1);
    rdc("control", 12'h000, 0);
    for (i = 0; i < 11; i++) rdc("reset value", ADR[i], 0);
    wr(12'h0F0, ~VER);
    rdc("version", 12'h0F0, VER);
    rdc("unmapped", 12'h0FC, 0);
    for (i = 0; i < 11; i++) begin
      v = $urandom;
      wr(ADR[i], v);
      rdc("readback", ADR[i], v & MSK[i]);
    end
    wr(12'h008, 0);
    wr(12'h00C, 32'h0000_0FFF);
    // every algorithm code and packing codes 0 to 2 through a shadow update
    for (i = 0; i < 4; i++) begin
      m = dictl_mode_s'($urandom & 32'h0003_03BF);
      m.algorithm = dictl_alg_e'(i[1:0]);
      m.packing = dictl_pack_e'(2'(i % 3));
      m.segmented_frame_mode = i[1];
      wr(12'h004, m);
      wr(12'h000, 3);
      check("mode held", shadow.mode, prev);
      check("enable held", shadow.enable, i != 0);
      fb_pulse();
      check("mode", shadow.mode, m);
      check("enable", shadow.enable, 1);
      rdc("update consumed", 12'h000, 2);
      rdc("flags", 12'h00C, 32'h0000_0041);
      wr(12'h00C, 32'h0000_0FFF);
      prev = m;
    end
    // a cancelled update leaves the shadow alone
    wr(12'h004, ~m);
    wr(12'h000, 3);
    wr(12'h000, 2);
    fb_pulse();
    check("cancel", shadow.mode, m);
    rdc("frame only", 12'h00C, 32'h0000_0040);
    wr(12'h000, 6);
    fb_pulse();
    check("accept wait", shadow.accept, 0);
    @(posedge sys_clk);
    #1 in_frame_start = 1'b1;
    @(posedge sys_clk);
    #1 in_frame_start = 1'b0;
    check("accept", shadow.accept, 1);
    wr(12'h008, 32'h0000_0F7F);
    wr(12'h00C, 32'h0000_0FFF);
    for (i = 0; i < 10; i++) begin
      ev_pulse(i);
      check("irq set", irq, 1);
      rdc("event flag", 12'h00C, exp_flag(i));
      wr(12'h00C, exp_flag(i));
      check("irq clear", irq, 0);
    end
    j = $urandom % 10;
    wr(12'h008, ~exp_flag(j) & 32'h0000_0F7F);
    ev_pulse(j);
    check("irq masked", irq, 0);
    wr(12'h008, exp_flag(j));
    check("irq enabled", irq, 1);
    wr(12'h00C, 32'h0000_0FFF);
    // soft reset keeps height and fade value, clears control side
    wr(12'h010, 32'd1080);
    wr(12'h014, 32'd1920);
    wr(12'h018, 32'd10);
    wr(12'h01C, 32'd70);
    wr(12'h020, 32'd17476);
    wr(12'h008, 32'h0000_0041);
    wr(12'h100, 1);
    for (i = 0; i < 40 && core_purge !== 1'b0; i++) @(posedge sys_clk) #1;
    check("purge end", core_purge, 0);
    rdc("self clear", 12'h100, 0);
    rdc("ctrl cleared", 12'h000, 0);
    rdc("mode cleared", 12'h004, 0);
    rdc("enable cleared", 12'h008, 0);
    rdc("height kept", 12'h010, 32'd1080);
    rdc("fade kept", 12'h020, 32'd17476);
    wr(12'h000, 1);
    fb_pulse();
    check("shadow height", shadow.height, 32'd1080);
    check("shadow fade", shadow.crossfade, 32'd17476);
    close_out();
  end
endmodule : deinterlacer_control_registers_test
`default_nettype wire

// file: verification/dictl_checker.sv
/* Port assertions for the deinterlacer control register bank.
   Assumes one clock domain and a bind into dictl_regs. */
`timescale 1ns/1ps
`default_nettype none
module dictl_checker
  import dictl_pkg::*;
#(
  parameter int SRST_LEN = 16
) (
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          resetn,
  // register port
  input wire logic          reg_sel,
  input wire logic          reg_wr,
  input wire logic [11:0]   reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic [31:0]   reg_rdata,
  // video path side
  input wire logic          frame_boundary,
  input wire logic          in_frame_start,
  input wire dictl_events_s events,
  input wire dictl_shadow_s shadow,
  input wire logic          strip_blanking,
  input wire logic          core_purge,
  input wire logic          irq
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] purge_cnt_q;
  // purge length is counted, a repetition of SRST_LEN would not unroll well
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) purge_cnt_q <= 8'h00;
    else purge_cnt_q <= core_purge ? purge_cnt_q + 8'h01 : 8'h00;
  end
  property p_strip; strip_blanking; endproperty
  property p_accept; $changed(shadow.accept) |-> $past(in_frame_start || core_purge); endproperty
  property p_commit;
    ($changed(shadow.enable) || $changed(shadow.mode)) |-> $past(frame_boundary) || core_purge;
  endproperty
  property p_irq_fall;
    $fell(irq) |-> core_purge ||
      $past(reg_sel && reg_wr && (reg_addr == 12'h00C || reg_addr == 12'h008));
  endproperty
  property p_purge_len; $fell(core_purge) |-> purge_cnt_q == SRST_LEN; endproperty
  property p_purge_start;
    reg_sel && reg_wr && reg_addr == 12'h100 && reg_wdata[0] && !core_purge &&
      !$past(core_purge) |-> ##[1:2] core_purge;
  endproperty
  property p_srst_zero;
    core_purge && $past(core_purge) |-> shadow.mode == '0 && !shadow.enable;
  endproperty
  sequence s_height_rd;
    reg_sel && reg_wr && reg_addr == 12'h010 ##1 !reg_sel ##1 reg_sel && !reg_wr && reg_addr == 12'h010;
  endsequence
  property p_height; s_height_rd |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000_07FF); endproperty
  a_strip: assert property (p_strip) else $error("blanking strip low");
  a_accept: assert property (p_accept) else $error("accept moved off frame start");
  a_commit: assert property (p_commit) else $error("shadow moved off boundary");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
  a_purge_len: assert property (p_purge_len) else $error("purge length wrong");
  a_purge_start: assert property (p_purge_start) else $error("purge did not start");
  a_srst_zero: assert property (p_srst_zero) else $error("shadow kept in purge");
  a_height: assert property (p_height) else $error("height readback wrong");
  c_purge: cover property ($fell(core_purge));
  c_irq: cover property ($rose(irq));
  c_commit: cover property ($changed(shadow.mode));
endmodule : dictl_checker
bind dictl_regs dictl_checker #(.SRST_LEN(SRST_LEN)) i_checker (.sys_clk(sys_clk),
  .resetn(resetn), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_boundary(frame_boundary),
  .in_frame_start(in_frame_start), .events(events), .shadow(shadow),
  .strip_blanking(strip_blanking), .core_purge(core_purge), .irq(irq));
`default_nettype wire

// file: verification/dictl_host.sv
/* Processor model on the register port of the deinterlacer control bank.
   Assumes it is called from the bench just after a rising sys_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module dictl_host (
  // clock
  input wire logic         sys_clk,
  // register port
  output var logic         reg_sel,
  output var logic         reg_wr,
  output var logic [11:0]  reg_addr,
  output var logic [31:0]  reg_wdata,
  input wire logic [31:0]  reg_rdata
);
  // ************************************************************
  // bus cycle
  // ************************************************************
  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
  end
  // one access, held over the taking edge, read data taken after it
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b1;
    reg_wr = wr;
    reg_addr = addr;
    reg_wdata = data;
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b0;
    reg_addr = ~reg_addr; // released lines must not keep the last value
    reg_wdata = ~reg_wdata;
    rdata = reg_rdata;
  endtask : access
endmodule : dictl_host
`default_nettype wire
